/* src/eamp_top.sv */
// frame writer onto the packet memory bus plus external destination sampling
// assumes rx fields are stable with the first byte and pclk is the memory cycle
//
// Summary of operation
// - upper flag nibble is driven on memory word bits 35 to 32.
// - frame start nibble is 01XX with bit 35 low; bit 35 high marks link word.
// - with bit 35 high, bits 34 to 32 are parity of the three low bytes.
// - uplink operation puts the pre-tag nibble in pointer bits 31 to 28.
// - pointer bits 27 to 24 carry the binary source port number.
// - one flag byte accompanies every eight data bytes.
// - with buffer end set, flag carries valid byte count and status nibble.
// - buffer end after each 64 bytes; frame end bit 3 only on last buffer.
// - external code overrides internal match unless it is the no-op code.
// - select and no-op both high uses internal matching when enabled.
// - select high, no-op low: low four bits pick one port or broadcast.
// - select low: fifteen low bits are a destination port mask.
// - an all-zero mask-mode code discards the frame.
// - mask-mode frames with a non-zero mask go out through the ordered broadcast table.
// - single-address mode limits internally matched broadcast to the source port's VLAN group.
`timescale 1ns/1ps
module eamp_top #(
    parameter int unsigned PORTS = eamp_pkg::EAMP_PORTS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    input  wire logic [3:0]  rx_port,
    input  wire logic [3:0]  rx_pretag,
    input  wire logic [2:0]  rx_status,
    input  wire logic        rx_is_bcast,
    input  wire logic        int_match_valid,
    input  wire logic [14:0] int_match_mask,
    input  wire logic [15:0] external_match_port,
    output logic      [35:0] mem_data,
    output logic             mem_row_strobe_n,
    output logic             mem_col_strobe_n,
    output logic             fwd_valid,
    output logic      [15:0] fwd_mask,
    output logic             fwd_discard,
    output logic             fwd_obl
);
    import eamp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [2:0]  ctrl_q;
    logic [14:0] vlan_q [PORTS];
    logic [15:0] fcount_q;

    wire         wr_w   = psel && penable && pwrite;
    wire         ctrl_hit_w   = (paddr == EAMP_CTRL_OFF);
    wire         result_hit_w = (paddr == EAMP_RESULT_OFF);
    wire         fcount_hit_w = (paddr == EAMP_FCOUNT_OFF);
    wire [11:0]  vlan_rel_w   = paddr - EAMP_VLAN_OFF;
    wire [9:0]   vlan_idx_w   = vlan_rel_w[11:2];
    wire         vlan_hit_w   = (paddr >= EAMP_VLAN_OFF) && (paddr[1:0] == 2'b00)
                                && (vlan_idx_w < 10'(PORTS));
    wire         hit_w = ctrl_hit_w || result_hit_w || fcount_hit_w || vlan_hit_w;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_w;

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (ctrl_hit_w)
            prdata = {29'h0000_0000, ctrl_q};
        else if (result_hit_w)
            prdata = {13'h0000, fwd_obl, fwd_discard, fwd_valid, fwd_mask};
        else if (fcount_hit_w)
            prdata = {16'h0000, fcount_q};
        else if (vlan_hit_w)
            prdata = {17'h0_0000, vlan_q[vlan_idx_w[3:0]]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= EAMP_CTRL_RST;
        else if (wr_w && ctrl_hit_w)
            ctrl_q <= pwdata[2:0];
    end

    genvar gi;
    generate
        for (gi = 0; gi < PORTS; gi++)
        begin : g_vlan
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    vlan_q[gi] <= EAMP_VLAN_RST;
                else if (wr_w && vlan_hit_w && (vlan_idx_w == 10'(gi)))
                    vlan_q[gi] <= pwdata[14:0];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // frame writer
    eamp_state_t state_q;
    eamp_state_t state_d;
    logic [63:0] grp_q;
    logic [2:0]  bcnt_q;
    logic [2:0]  gcnt_q;
    logic        last_q;
    logic [3:0]  port_q;
    logic [3:0]  tag_q;
    logic [2:0]  stat_q;
    logic        bcast_q;
    logic [23:0] bufptr_q;
    logic [35:0] mem_data_d;
    logic        col_d;
    logic        row_d;

    wire         take_w   = (state_q == EAMP_GATHER) && rx_valid;
    wire         grp_full_w = take_w && (rx_last || (bcnt_q == EAMP_GRP_BYTE_LAST));
    // a buffer ends after eight groups or at the frame's last group
    wire         eob_w    = last_q || (gcnt_q == EAMP_GROUPS_LAST);
    wire [7:0]   flag_w   = eob_w ? {1'b1, bcnt_q, last_q, stat_q} : 8'h00;
    wire [3:0]   tag_w    = ctrl_q[EAMP_CTRL_UPLINK] ? tag_q : 4'h0;
    wire [31:0]  link_w   = {16'h0000, fwd_mask};
    wire [2:0]   par_w    = {^link_w[23:16], ^link_w[15:8], ^link_w[7:0]};
    wire         dec_done_w;

    assign rx_ready = (state_q == EAMP_GATHER);

    always_comb
    begin
        state_d    = state_q;
        mem_data_d = 36'h0_0000_0000;
        col_d      = 1'b1;
        row_d      = 1'b1;
        case (state_q)
            EAMP_IDLE:
                if (rx_valid)
                    state_d = EAMP_FPTR;
            EAMP_FPTR:
            begin
                // start nibble 01XX with bit 35 low marks a frame start
                mem_data_d = {EAMP_SOF_CODE, 2'b00, tag_w, port_q, bufptr_q};
                col_d      = 1'b0;
                row_d      = 1'b0;
                state_d    = EAMP_GATHER;
            end
            EAMP_GATHER:
            begin
                row_d = 1'b0;
                if (grp_full_w)
                    state_d = EAMP_EMIT_HI;
            end
            EAMP_EMIT_HI:
            begin
                mem_data_d = {flag_w[7:4], grp_q[31:0]};
                col_d      = 1'b0;
                row_d      = 1'b0;
                state_d    = EAMP_EMIT_LO;
            end
            EAMP_EMIT_LO:
            begin
                mem_data_d = {flag_w[3:0], grp_q[63:32]};
                col_d      = 1'b0;
                row_d      = 1'b0;
                state_d    = last_q ? EAMP_WAIT_DEC : EAMP_GATHER;
            end
            EAMP_WAIT_DEC:
                if (dec_done_w)
                    state_d = fwd_obl ? EAMP_LINK : EAMP_IDLE;
            EAMP_LINK:
            begin
                // link word: bit 35 high, parity of the three low bytes below it
                mem_data_d = {1'b1, par_w, link_w};
                col_d      = 1'b0;
                row_d      = 1'b0;
                state_d    = EAMP_IDLE;
            end
            default:
                state_d = EAMP_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q          <= EAMP_IDLE;
            mem_data         <= 36'h0_0000_0000;
            mem_col_strobe_n <= 1'b1;
            mem_row_strobe_n <= 1'b1;
        end
        else
        begin
            state_q          <= state_d;
            mem_data         <= mem_data_d;
            mem_col_strobe_n <= col_d;
            mem_row_strobe_n <= row_d;
        end
    end

    // frame side fields are latched with the first byte offered, status with the last byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_q  <= 4'h0;
            tag_q   <= 4'h0;
            stat_q  <= 3'h0;
            bcast_q <= 1'b0;
        end
        else if (state_q == EAMP_IDLE && rx_valid)
        begin
            port_q  <= rx_port;
            tag_q   <= rx_pretag;
            bcast_q <= rx_is_bcast;
        end
        else if (take_w && rx_last)
            stat_q  <= rx_status;
    end

    // byte gathering; bcnt wraps so a full group reports zero valid bytes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grp_q  <= 64'h0000_0000_0000_0000;
            bcnt_q <= 3'h0;
            last_q <= 1'b0;
        end
        else if (state_q == EAMP_FPTR)
        begin
            bcnt_q <= 3'h0;
            last_q <= 1'b0;
        end
        else if (take_w)
        begin
            grp_q[8*bcnt_q +: 8] <= rx_data;
            bcnt_q <= bcnt_q + 3'h1;
            last_q <= rx_last;
        end
        else if (state_q == EAMP_EMIT_LO)
            grp_q  <= 64'h0000_0000_0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gcnt_q   <= 3'h0;
            bufptr_q <= 24'h00_0000;
            fcount_q <= 16'h0000;
        end
        else if (state_q == EAMP_FPTR)
            gcnt_q   <= 3'h0;
        else if (state_q == EAMP_EMIT_LO)
        begin
            gcnt_q <= gcnt_q + 3'h1;
            if (eob_w)
                bufptr_q <= bufptr_q + 24'h00_0001;
            if (last_q)
                fcount_q <= fcount_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // response window and destination decision
    logic [3:0]  dcnt_q;
    logic        dbusy_q;
    logic        dhave_q;

    eamp_dec_if dec ();

    assign dec.code        = external_match_port;
    assign dec.int_en      = ctrl_q[EAMP_CTRL_INT_EN];
    assign dec.int_valid   = int_match_valid;
    assign dec.int_mask    = int_match_mask;
    assign dec.is_bcast    = bcast_q;
    assign dec.single_addr = ctrl_q[EAMP_CTRL_SINGLE];
    assign dec.vlan_map    = vlan_q[port_q];

    eamp_dest_decode u_decode (
        .d (dec.decoder)
    );

    // lookup logic has the full window, so the code is taken at its very end
    wire         sample_w = dbusy_q && (dcnt_q == EAMP_RESP_CNT);
    assign dec_done_w = dhave_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dcnt_q  <= 4'h0;
            dbusy_q <= 1'b0;
            dhave_q <= 1'b0;
        end
        else if (state_q == EAMP_FPTR)
        begin
            dcnt_q  <= 4'h0;
            dbusy_q <= 1'b1;
            dhave_q <= 1'b0;
        end
        else if (sample_w)
        begin
            dbusy_q <= 1'b0;
            dhave_q <= 1'b1;
        end
        else if (dbusy_q)
            dcnt_q  <= dcnt_q + 4'h1;
    end

    // one decision per frame, held until the next frame's decision
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fwd_valid   <= 1'b0;
            fwd_mask    <= 16'h0000;
            fwd_discard <= 1'b0;
            fwd_obl     <= 1'b0;
        end
        else
        begin
            fwd_valid <= sample_w;
            if (sample_w)
            begin
                fwd_mask    <= dec.mask;
                fwd_discard <= dec.discard;
                fwd_obl     <= dec.use_obl;
            end
        end
    end
endmodule : eamp_top

/* src/eamp_pkg.sv */
// constants, field layouts and state types for the external match port
// assumes a 36-bit packet memory word and an APB register slave
package eamp_pkg;
    localparam int unsigned EAMP_CLK_MHZ      = 25;
    localparam int unsigned EAMP_RESP_CYCLES  = 12;
    localparam logic [3:0]  EAMP_RESP_CNT     = 4'(EAMP_RESP_CYCLES);
    localparam int unsigned EAMP_PORTS        = 15;
    localparam int unsigned EAMP_GROUP_BYTES  = 8;
    localparam int unsigned EAMP_BUF_BYTES    = 64;
    localparam logic [2:0]  EAMP_GROUPS_LAST  = 3'(EAMP_BUF_BYTES / EAMP_GROUP_BYTES - 1);
    localparam logic [2:0]  EAMP_GRP_BYTE_LAST = 3'(EAMP_GROUP_BYTES - 1);
    // memory word and external match code field positions
    localparam int unsigned EAMP_FLAG_MSB     = 35;
    localparam int unsigned EAMP_TAG_LSB      = 28;
    localparam int unsigned EAMP_SRC_LSB      = 24;
    localparam logic [1:0]  EAMP_SOF_CODE     = 2'b01;
    localparam int unsigned EAMP_SEL_BIT      = 15;
    localparam int unsigned EAMP_NOOP_BIT     = 4;
    localparam logic [3:0]  EAMP_BCAST_CODE   = 4'b1111;
    // register byte offsets, reset values and control bits
    localparam logic [11:0] EAMP_CTRL_OFF     = 12'h000;
    localparam logic [11:0] EAMP_RESULT_OFF   = 12'h004;
    localparam logic [11:0] EAMP_FCOUNT_OFF   = 12'h008;
    localparam logic [11:0] EAMP_VLAN_OFF     = 12'h040;
    localparam logic [2:0]  EAMP_CTRL_RST     = 3'h0;
    localparam logic [14:0] EAMP_VLAN_RST     = 15'h7fff;
    localparam int unsigned EAMP_CTRL_INT_EN  = 0;
    localparam int unsigned EAMP_CTRL_UPLINK  = 1;
    localparam int unsigned EAMP_CTRL_SINGLE  = 2;
    typedef enum logic [2:0] {
        EAMP_IDLE, EAMP_FPTR, EAMP_GATHER, EAMP_EMIT_HI, EAMP_EMIT_LO, EAMP_WAIT_DEC, EAMP_LINK
    } eamp_state_t;
endpackage : eamp_pkg

/* src/eamp_dec_if.sv */
// carrier between the frame writer and the destination decoder
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface eamp_dec_if;
    logic [15:0] code;
    logic        int_en;
    logic        int_valid;
    logic [14:0] int_mask;
    logic        is_bcast;
    logic        single_addr;
    logic [14:0] vlan_map;
    logic [15:0] mask;
    logic        discard;
    logic        use_obl;
    modport writer (output code, int_en, int_valid, int_mask, is_bcast,
                    output single_addr, vlan_map, input mask, discard, use_obl);
    modport decoder (input code, int_en, int_valid, int_mask, is_bcast,
                     input single_addr, vlan_map, output mask, discard, use_obl);
endinterface : eamp_dec_if

/* src/eamp_dest_decode.sv */
// combinational decode of the external destination code into a port mask
// assumes code and internal match inputs are stable while sampled
`timescale 1ns/1ps
module eamp_dest_decode (
    eamp_dec_if.decoder d
);
    import eamp_pkg::*;

    wire         sel_w  = d.code[EAMP_SEL_BIT];
    wire         noop_w = d.code[EAMP_NOOP_BIT];
    wire [3:0]   pcode_w = d.code[3:0];
    wire [14:0]  vlan_w;
    wire [14:0]  int_w;
    wire [15:0]  single_w;
    wire [15:0]  bitmap_w;

    // broadcast from a port stays inside its group
    assign vlan_w   = (d.single_addr && d.is_bcast) ? d.vlan_map : 15'h7fff;
    assign int_w    = d.int_mask & vlan_w;
    // bit 15 of the mask stands for the broadcast channel
    assign single_w = (pcode_w == EAMP_BCAST_CODE) ? 16'h8000
                      : (16'h0001 << pcode_w);
    assign bitmap_w = {1'b0, d.code[14:0]};

    ////////////////////////////////////////////////////////////////////////
    // priority: external code wins unless it is the no-operation code
    assign d.mask = (sel_w && noop_w) ? {1'b0, int_w}
                    : sel_w ? single_w
                    : bitmap_w;
    // no-op with internal matching disabled leaves nowhere to go
    assign d.discard = (sel_w && noop_w)
                       ? !(d.int_en && d.int_valid && (int_w != 15'h0000))
                       : (!sel_w && (d.code[14:0] == 15'h0000));
    // mask mode goes through the ordered broadcast table unless the mask is all zero
    assign d.use_obl = !sel_w && (d.code[14:0] != 15'h0000);
endmodule : eamp_dest_decode

/* dv/eamp_checker.sv */
// concurrent checks on the external match port pins of eamp_top
// assumes one pclk domain, bound into every eamp_top instance
`timescale 1ns/1ps
module eamp_checker #(
    parameter int unsigned PORTS = eamp_pkg::EAMP_PORTS
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [35:0] mem_data,
    input wire logic        mem_row_strobe_n,
    input wire logic        mem_col_strobe_n,
    input wire logic        fwd_valid,
    input wire logic [15:0] fwd_mask,
    input wire logic        fwd_discard,
    input wire logic        fwd_obl,
    input wire logic [15:0] external_match_port
);
    import eamp_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////
    property p_ptr_nibble;
        $fell(mem_row_strobe_n) |-> !mem_col_strobe_n
            && (mem_data[35] ? mem_data[34:32] == {^mem_data[23:16], ^mem_data[15:8],
                                                   ^mem_data[7:0]}
                             : mem_data[34]);
    endproperty
    a_ptr_nibble: assert property (p_ptr_nibble)
        else $error("pointer word lacks start nibble");
    property p_decide_time;
        $fell(mem_row_strobe_n) && !mem_data[35]
            |-> !fwd_valid [*8] ##1 !fwd_valid [*5] ##1 fwd_valid;
    endproperty
    a_decide_time: assert property (p_decide_time)
        else $error("decision not at end of window");
    property p_pulse;
        fwd_valid |=> !fwd_valid;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("decision pulse too long");
    property p_hold;
        !fwd_valid |-> $stable(fwd_mask) && $stable(fwd_discard) && $stable(fwd_obl);
    endproperty
    a_hold: assert property (p_hold)
        else $error("decision changed between frames");
    property p_single;
        fwd_valid && $past(external_match_port[15]) && !$past(external_match_port[4])
            |-> fwd_mask == (16'h0001 << $past(external_match_port[3:0])) && !fwd_obl;
    endproperty
    a_single: assert property (p_single)
        else $error("single port code misrouted");
    property p_bitmap;
        fwd_valid && !$past(external_match_port[15]) && $past(external_match_port[14:0]) != 0
            |-> fwd_mask == {1'b0, $past(external_match_port[14:0])} && fwd_obl;
    endproperty
    a_bitmap: assert property (p_bitmap)
        else $error("mask code misrouted");
    property p_zero;
        fwd_valid && $past(external_match_port) == 16'h0000 |-> fwd_discard && !fwd_obl;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero code not discarded");
    property p_noop;
        fwd_valid && $past(external_match_port[15]) && $past(external_match_port[4])
            |-> !fwd_obl && !fwd_mask[15];
    endproperty
    a_noop: assert property (p_noop)
        else $error("no-op code not internal");
    c_obl: cover property (fwd_valid && fwd_obl);
    c_disc: cover property (fwd_valid && fwd_discard);
    c_bcast: cover property (fwd_valid && fwd_mask == 16'h8000);
endmodule : eamp_checker

bind eamp_top eamp_checker #(.PORTS(PORTS)) u_eamp_checker (
    .pclk(pclk), .presetn(presetn), .mem_data(mem_data),
    .mem_row_strobe_n(mem_row_strobe_n), .mem_col_strobe_n(mem_col_strobe_n),
    .fwd_valid(fwd_valid), .fwd_mask(fwd_mask), .fwd_discard(fwd_discard),
    .fwd_obl(fwd_obl), .external_match_port(external_match_port));

/* dv/eamp_lookup_model.sv */
// lookup hardware that snoops the memory bus and answers with a code
// assumes the bench sets code_in and lat_in before each frame
`timescale 1ns/1ps
module eamp_lookup_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [35:0] mem_data,
    input wire logic        mem_row_strobe_n,
    input wire logic        mem_col_strobe_n,
    input wire logic        fwd_valid,
    input wire logic [15:0] code_in,
    input wire logic [3:0]  lat_in,
    output logic     [15:0] external_match_port
);
    logic        row_q;
    logic        busy_q;
    logic [3:0]  cnt_q;
    logic [31:0] addr_q;
    // row falling with a 01xx nibble and bit 35 low is a new frame
    wire logic sof_w = row_q && !mem_row_strobe_n && !mem_col_strobe_n
                       && mem_data[35:34] == 2'b01;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            row_q <= 1'b1;
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            addr_q <= 32'h0000_0000;
            external_match_port <= 16'h5a5a;
        end
        else
        begin
            row_q <= mem_row_strobe_n;
            if (sof_w && !busy_q)
            begin
                busy_q <= 1'b1;
                cnt_q <= 4'h0;
            end
            else if (busy_q)
            begin
                cnt_q <= cnt_q + 4'h1;
                if (!mem_col_strobe_n && cnt_q == 4'h0)
                    addr_q <= mem_data[31:0];
                if (cnt_q == lat_in)
                    external_match_port <= code_in;
                // outside the window the lines carry garbage, never the old code
                if (fwd_valid)
                begin
                    busy_q <= 1'b0;
                    external_match_port <= ~code_in;
                end
            end
        end
    end
endmodule : eamp_lookup_model

/* dv/eamp_top_tb.sv */
// self-checking bench: apb register access and frames with external codes
// assumes eamp_top, the bound checker and the lookup model
`timescale 1ns/1ps
module eamp_top_tb;
    import eamp_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, rx_valid, rx_last, rx_is_bcast;
    logic        int_match_valid, rx_ready, pready, pslverr, row_n, col_n;
    logic        fwd_valid, fwd_discard, fwd_obl, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  rx_data;
    logic [3:0]  rx_port, rx_pretag, lat;
    logic [2:0]  rx_status;
    logic [14:0] int_match_mask;
    logic [15:0] ext, fwd_mask, code;
    logic [35:0] mem_data, lw;
    logic [35:0] words[$];
    int          fail_count, num_checks, fwd_seen;
    logic [2:0]  tc[8] = '{3, 3, 3, 3, 3, 0, 5, 3};
    logic [15:0] tcode[8] = '{16'h8003, 16'h800f, 16'h4081, 16'h0000,
                              16'h8010, 16'h8010, 16'h8010, 16'h0004};
    logic [15:0] tmask[8] = '{16'h0008, 16'h8000, 16'h4081, 16'h0000,
                              16'h0031, 16'h0000, 16'h0001, 16'h0004};
    logic [7:0]  tdisc = 8'h28;
    logic [7:0]  tobl = 8'h84;
    eamp_top #(.PORTS(EAMP_PORTS)) u_eamp_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
        .rx_port(rx_port), .rx_pretag(rx_pretag), .rx_status(rx_status),
        .rx_is_bcast(rx_is_bcast), .int_match_valid(int_match_valid),
        .int_match_mask(int_match_mask), .external_match_port(ext), .mem_data(mem_data),
        .mem_row_strobe_n(row_n), .mem_col_strobe_n(col_n), .fwd_valid(fwd_valid),
        .fwd_mask(fwd_mask), .fwd_discard(fwd_discard), .fwd_obl(fwd_obl));
    eamp_lookup_model u_eamp_lookup_model (
        .pclk(pclk), .presetn(presetn), .mem_data(mem_data), .mem_row_strobe_n(row_n),
        .mem_col_strobe_n(col_n), .fwd_valid(fwd_valid), .code_in(code), .lat_in(lat),
        .external_match_port(ext));
    ////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (col_n === 1'b0)
            words.push_back(mem_data);
        if (fwd_valid === 1'b1)
            fwd_seen++;
    end
    function automatic logic [7:0] bv(input int i);
        return 8'(i * 5 + 1);
    endfunction : bv
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        chk(n < 50, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic frame(input int nb, input logic [15:0] c, input logic [3:0] l);
        int i;
        int n;
        @(posedge pclk);
        code <= c;
        lat <= l;
        words.delete();
        fwd_seen = 0;
        rx_valid <= 1'b1;
        rx_data <= bv(0);
        rx_last <= (nb == 1);
        i = 0;
        n = 0;
        while ((i < nb || fwd_seen == 0) && n < 800)
        begin
            @(posedge pclk);
            n++;
            if (rx_ready === 1'b1 && i < nb)
            begin
                i++;
                rx_data <= bv(i);
                rx_last <= (i == nb - 1);
                rx_valid <= (i < nb);
            end
        end
        repeat (6) @(posedge pclk);
        chk(n < 800, 1'b1);
    endtask : frame
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        summarize();
    end
    ////////////////////
    initial
    begin
        {psel, penable, pwrite, rx_valid, rx_last} = 5'h00;
        {paddr, pwdata, rx_data, code, lat} = '0;
        {rx_port, rx_pretag, rx_status} = {4'h0, 4'h9, 3'h5};
        {rx_is_bcast, int_match_valid, int_match_mask} = {2'h3, 15'h0031};
        {fail_count, num_checks, fwd_seen} = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, EAMP_CTRL_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, EAMP_VLAN_OFF, 32'h0);
        chk(rd, {17'h0, EAMP_VLAN_RST});
        apb(1'b0, 12'h100, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        apb(1'b1, EAMP_VLAN_OFF + 12'h034, 32'h0000_0003);
        $display("test registers done");
        for (int k = 0; k < 8; k++)
        begin
            rx_port <= 4'(k + 7);
            apb(1'b1, EAMP_CTRL_OFF, {29'h0, tc[k]});
            frame(4, tcode[k], k[0] ? 4'h8 : 4'h1);
            chk(words[0][35:24], {4'b0100, tc[k][1] ? 4'h9 : 4'h0, 4'(k + 7)});
            chk(words[1], {4'b1100, bv(3), bv(2), bv(1), bv(0)});
            chk(words[2], {4'b1101, 32'h0});
            chk({fwd_discard, fwd_obl}, {tdisc[k], tobl[k]});
            if (!tdisc[k])
                chk(fwd_mask, tmask[k]);
            lw = words[$];
            if (tobl[k])
                chk({lw[35:32], lw[15:0]}, {2'b10, ^tmask[k][15:8], ^tmask[k][7:0], tmask[k]});
        end
        $display("test codes done");
        apb(1'b1, EAMP_CTRL_OFF, 32'h0000_0003);
        frame(72, 16'h8003, 4'h8);
        chk(words[1][35:32], 4'h0);
        chk({words[15][35:32], words[16][35]}, {4'b1000, 1'b0});
        chk({words[17][35:32], words[18][35:32]}, {4'b1000, 4'b1101});
        chk(words[15][31:0], {bv(59), bv(58), bv(57), bv(56)});
        apb(1'b0, EAMP_FCOUNT_OFF, 32'h0);
        chk(rd, 32'h0000_0009);
        apb(1'b0, EAMP_RESULT_OFF, 32'h0);
        chk(rd, 32'h0000_0008);
        $display("test long frame done");
        summarize();
    end
endmodule : eamp_top_tb
